// file: inc/wdrs_pkg.sv
package wdrs_pkg;
   // Clock and derived timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int LVR_HOLD_MS   = 10;
   localparam int LVR_HOLD_CYC  = LVR_HOLD_MS * (CLK_HZ / 1000);
   localparam int MC_DIV        = 12;
   localparam int USB_BIT_HZ    = 1_500_000;
   localparam int SE0_SMP_CYC   = CLK_HZ / USB_BIT_HZ;
   localparam int SE0_MIN       = 4;
   localparam int SE0_MAX       = 8;
   // Watchdog geometry
   localparam int WDT_W         = 22;
   localparam int WDT_LOAD_W    = 7;
   localparam int WDT_LOW_W     = WDT_W - WDT_LOAD_W;
   localparam int WDT_PULSE_EXP = 15;
   localparam int WDT_PULSE_MC  = 2 ** WDT_PULSE_EXP;
   // Counter widths
   localparam int LVR_CW        = $clog2(LVR_HOLD_CYC + 1);
   localparam int PULSE_CW      = WDT_PULSE_EXP + 1;
   localparam int PRESC_W       = 4;
   localparam int SMP_W         = 4;
   localparam int RUN_W         = 4;
   // SFR map
   localparam int SFR_W                     = 8;
   localparam logic [7:0] ADDR_WDT_RELOAD   = 8'hA6;
   localparam logic [7:0] ADDR_WDT_KEY      = 8'hAE;
   localparam logic [7:0] ADDR_PWR_CTRL     = 8'h87;
   localparam logic [7:0] ADDR_USB_IRQ_EN   = 8'hE1;
   localparam logic [7:0] ADDR_USB_IRQ_STA  = 8'hE2;
   localparam int PWR_LVR_DIS_BIT           = 5;
   localparam int UIE_RST_CPU_BIT           = 6;
   localparam int UIS_RST_FLAG_BIT          = 0;
   localparam logic [7:0] WDT_KEY_DIS       = 8'h55;
   localparam logic [7:0] WDT_KEY_RST       = 8'h00;
   localparam logic [7:0] SFR_ZERO          = 8'h00;

   typedef struct packed {
      logic                 pin_m;
      logic                 pin_s;
      logic                 lv_m;
      logic                 lv_s;
      logic                 se0_m;
      logic                 se0_s;
      logic [PRESC_W-1:0]   presc;
      logic [SMP_W-1:0]     smp_cnt;
      logic [RUN_W-1:0]     se0_run;
      logic                 bus_reset_flag;
      logic                 bus_reset_cpu_enable;
      logic                 low_volt_reset_disable;
      logic                 lvr_hold;
      logic [LVR_CW-1:0]    lvr_cnt;
      logic [WDT_W-1:0]     watchdog_counter;
      logic [SFR_W-1:0]     wdt_key;
      logic                 wdt_pulse;
      logic [PULSE_CW-1:0]  pulse_cnt;
      logic [SFR_W-1:0]     rdata;
      logic                 rst_n;
   } wdrs_state_t;
endpackage

// file: rtl/wdrs_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: After a low-voltage event ends, internal reset stays on 10 ms.
// RULE_02: Low-voltage reset is on after power-up; software may disable it.
// RULE_03: Power control bit 5 set to one disables low-voltage reset.
// RULE_04: Low-voltage detection ignores Idle and Power-down.
// RULE_05: SE0 held for 4 consecutive samples sets the bus-reset flag.
// RULE_06: With enable bit 6 set, a bus reset also resets the CPU.
// RULE_07: A 22-bit counter counts machine cycles while enabled.
// RULE_08: Counter overflow after 4194304 machine cycles raises reset.
// RULE_09: The watchdog leaves every reset enabled.
// RULE_10: A clear write loads its 7 low bits into the counter top bits.
// RULE_11: A clear write also zeroes the 15 low counter bits.
// RULE_12: Key 55h disables the watchdog; any other key enables it.
// RULE_13: Watchdog and reset logic keep running in Idle.
// RULE_14: A watchdog reset lasts 2^15 machine cycles of 12 clocks.
// RULE_15: Software in Idle must wake by timer and service the watchdog.
// RULE_16: Internal reset is the OR of pin, low-voltage, USB and watchdog.
module wdrs_top #(
   parameter int unsigned P_LVR_HOLD_CYC = wdrs_pkg::LVR_HOLD_CYC,
   parameter int unsigned P_WDT_PULSE_MC = wdrs_pkg::WDT_PULSE_MC
) (
   // Clock and power-on reset
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   // Reset sources from pins
   input  wire logic                        i_rst_pin_n,
   input  wire logic                        i_low_volt,
   input  wire logic                        i_usb_se0,
   // SFR bus
   input  wire logic [wdrs_pkg::SFR_W-1:0]  i_sfr_addr,
   input  wire logic [wdrs_pkg::SFR_W-1:0]  i_sfr_wdata,
   input  wire logic                        i_sfr_wr,
   input  wire logic                        i_sfr_rd,
   output logic      [wdrs_pkg::SFR_W-1:0]  o_sfr_rdata,
   // Merged internal reset
   output logic                             o_int_rst_n
);
   import wdrs_pkg::*;

   wdrs_state_t st_reg;
   wdrs_state_t st_next;
   logic        mc_tick;
   logic        smp_tick;
   logic        lvr_act;
   logic        se0_det;
   logic        usb_req;
   logic        wdt_en;
   logic        wdt_ovf;
   logic        rst_req;
   logic        wr_reload;
   logic        wr_key;
   logic        wr_pwr;
   logic        wr_uie;
   logic        wr_uis;
   logic        pulse_end;
   logic        hold_end;

   function automatic logic sfr_hit(input logic [SFR_W-1:0] a,
                                    input logic [SFR_W-1:0] off);
      return a == off;
   endfunction

   function automatic logic [SFR_W-1:0] sfr_read(
      input logic [SFR_W-1:0] a,
      input wdrs_state_t      s);
      logic [SFR_W-1:0] d;
      d = SFR_ZERO;
      if (sfr_hit(a, ADDR_WDT_KEY)) begin
         d = s.wdt_key;
      end else if (sfr_hit(a, ADDR_PWR_CTRL)) begin
         d[PWR_LVR_DIS_BIT] = s.low_volt_reset_disable;
      end else if (sfr_hit(a, ADDR_USB_IRQ_EN)) begin
         d[UIE_RST_CPU_BIT] = s.bus_reset_cpu_enable;
      end else if (sfr_hit(a, ADDR_USB_IRQ_STA)) begin
         d[UIS_RST_FLAG_BIT] = s.bus_reset_flag;
      end
      return d;
   endfunction

   assign wr_reload = i_sfr_wr & sfr_hit(i_sfr_addr, ADDR_WDT_RELOAD);
   assign wr_key    = i_sfr_wr & sfr_hit(i_sfr_addr, ADDR_WDT_KEY);
   assign wr_pwr    = i_sfr_wr & sfr_hit(i_sfr_addr, ADDR_PWR_CTRL);
   assign wr_uie    = i_sfr_wr & sfr_hit(i_sfr_addr, ADDR_USB_IRQ_EN);
   assign wr_uis    = i_sfr_wr & sfr_hit(i_sfr_addr, ADDR_USB_IRQ_STA);

   // Machine cycle and USB sample strobes
   assign mc_tick   = st_reg.presc == PRESC_W'(MC_DIV - 1);
   assign smp_tick  = st_reg.smp_cnt == SMP_W'(SE0_SMP_CYC - 1);
   // No Idle or Power-down term gates any source
   assign lvr_act   = st_reg.lv_s & ~st_reg.low_volt_reset_disable; // [RULE_04]
   assign se0_det   = st_reg.se0_run >= RUN_W'(SE0_MIN);
   assign usb_req   = se0_det & st_reg.bus_reset_cpu_enable;      // [RULE_06]
   assign wdt_en    = st_reg.wdt_key != WDT_KEY_DIS;              // [RULE_12]
   assign wdt_ovf   = wdt_en & mc_tick & st_reg.rst_n & ~wr_reload
                      & (&st_reg.watchdog_counter);               // [RULE_08]
   assign pulse_end = mc_tick
                      & (st_reg.pulse_cnt == PULSE_CW'(P_WDT_PULSE_MC - 1));
   assign hold_end  = st_reg.lvr_cnt == LVR_CW'(P_LVR_HOLD_CYC - 1);
   assign rst_req   = ~st_reg.pin_s | lvr_act | st_reg.lvr_hold
                      | usb_req | st_reg.wdt_pulse;               // [RULE_16]

   always_comb begin
      st_next = st_reg;
      // Pin synchronisers
      st_next.pin_m = i_rst_pin_n;
      st_next.pin_s = st_reg.pin_m;
      st_next.lv_m  = i_low_volt;
      st_next.lv_s  = st_reg.lv_m;
      st_next.se0_m = i_usb_se0;
      st_next.se0_s = st_reg.se0_m;
      // Free-running dividers, never stopped by Idle
      st_next.presc = mc_tick ? '0 : st_reg.presc + 1'b1;       // [RULE_13]
      st_next.smp_cnt = smp_tick ? '0 : st_reg.smp_cnt + 1'b1;

      // Low-voltage reset with stretched release
      if (wr_pwr) begin
         st_next.low_volt_reset_disable = i_sfr_wdata[PWR_LVR_DIS_BIT]; // [RULE_03]
      end
      if (lvr_act) begin
         st_next.lvr_hold = 1'b1;                                 // [RULE_01]
         st_next.lvr_cnt  = '0;
      end else if (st_reg.lvr_hold) begin
         st_next.lvr_cnt = st_reg.lvr_cnt + 1'b1;                 // [RULE_01]
         if (hold_end) begin
            st_next.lvr_hold = 1'b0;
         end
      end

      // USB bus-reset detection
      if (smp_tick) begin
         if (!st_reg.se0_s) begin
            st_next.se0_run = '0;
         end else if (st_reg.se0_run != RUN_W'(SE0_MAX)) begin
            st_next.se0_run = st_reg.se0_run + 1'b1;
         end
      end
      if (wr_uie) begin
         st_next.bus_reset_cpu_enable = i_sfr_wdata[UIE_RST_CPU_BIT];
      end
      if (wr_uis && i_sfr_wdata[UIS_RST_FLAG_BIT]) begin
         st_next.bus_reset_flag = 1'b0;
      end
      // Set beats a same-cycle clear
      if (smp_tick && st_reg.se0_s
          && st_reg.se0_run == RUN_W'(SE0_MIN - 1)) begin
         st_next.bus_reset_flag = 1'b1;                           // [RULE_05]
      end

      // Watchdog counter and key
      if (!st_reg.rst_n) begin
         st_next.watchdog_counter = '0;
         st_next.wdt_key          = WDT_KEY_RST;                  // [RULE_09]
      end else begin
         if (wr_key) begin
            st_next.wdt_key = i_sfr_wdata;                        // [RULE_12]
         end
         if (wr_reload) begin
            st_next.watchdog_counter =
               {i_sfr_wdata[WDT_LOAD_W-1:0], WDT_LOW_W'(0)};      // [RULE_10] [RULE_11]
         end else if (wdt_en && mc_tick) begin
            st_next.watchdog_counter =
               st_reg.watchdog_counter + 1'b1;                    // [RULE_07]
         end
      end

      // Watchdog reset pulse, counted in machine cycles
      if (wdt_ovf) begin
         st_next.wdt_pulse = 1'b1;                                // [RULE_08]
         st_next.pulse_cnt = '0;
      end else if (st_reg.wdt_pulse && mc_tick) begin
         st_next.pulse_cnt = st_reg.pulse_cnt + 1'b1;             // [RULE_14]
         if (pulse_end) begin
            st_next.wdt_pulse = 1'b0;
         end
      end

      // Registered read data
      if (i_sfr_rd) begin
         st_next.rdata = sfr_read(i_sfr_addr, st_reg);
      end
      st_next.rst_n = ~rst_req;                                   // [RULE_16]
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;                                            // [RULE_02]
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_sfr_rdata = st_reg.rdata;
   assign o_int_rst_n = st_reg.rst_n;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_lvr_release;
      $fell(lvr_act) && st_reg.lvr_hold;
   endsequence
   sequence s_se0_fourth;
      smp_tick && st_reg.se0_s && st_reg.se0_run == RUN_W'(SE0_MIN - 1);
   endsequence
   sequence s_wdt_wrap;
      wdt_en && mc_tick && st_reg.rst_n && !wr_reload
      && (&st_reg.watchdog_counter);
   endsequence

   a_lvr_assert_rst: assert property (lvr_act |=> ##1 !o_int_rst_n) // [RULE_01]
      else $error("low voltage did not assert reset");
   a_lvr_stretch: assert property (s_lvr_release |-> ##1 !o_int_rst_n [*8]) // [RULE_01]
      else $error("low voltage reset released early");
   a_lvr_disable_bit: assert property (wr_pwr |=>
      st_reg.low_volt_reset_disable == $past(i_sfr_wdata[PWR_LVR_DIS_BIT])) // [RULE_03]
      else $error("low voltage disable bit not taken");
   a_lvr_masked: assert property (st_reg.low_volt_reset_disable
      && st_reg.lv_s && st_reg.pin_s && !st_reg.lvr_hold && !usb_req
      && !st_reg.wdt_pulse |=> o_int_rst_n) // [RULE_02]
      else $error("disabled low voltage still active");
   a_busrst_flag_set: assert property (s_se0_fourth |=> st_reg.bus_reset_flag) // [RULE_05]
      else $error("bus reset flag not set after four samples");
   a_busrst_flag_early: assert property (smp_tick && !st_reg.se0_s
      && !st_reg.bus_reset_flag ##1 !wr_uis [*3] |=> !st_reg.bus_reset_flag) // [RULE_05]
      else $error("bus reset flag set too early");
   a_busrst_cpu_rst: assert property (se0_det && st_reg.bus_reset_cpu_enable
      |=> !o_int_rst_n) // [RULE_06]
      else $error("enabled bus reset did not reset cpu");
   a_wdt_count_up: assert property (wdt_en && mc_tick && st_reg.rst_n
      && !wr_reload |=> st_reg.watchdog_counter
      == $past(st_reg.watchdog_counter) + 1'b1) // [RULE_07]
      else $error("watchdog did not advance");
   a_wdt_hold_dis: assert property (!wdt_en && !wr_reload && st_reg.rst_n
      |=> $stable(st_reg.watchdog_counter)) // [RULE_12]
      else $error("disabled watchdog moved");
   a_wdt_overflow: assert property (s_wdt_wrap |=> st_reg.wdt_pulse
      ##1 !o_int_rst_n) // [RULE_08]
      else $error("overflow gave no reset");
   a_wdt_reload: assert property (wr_reload && st_reg.rst_n |=>
      st_reg.watchdog_counter == ($past(WDT_W'(i_sfr_wdata[WDT_LOAD_W-1:0]))
      << WDT_LOW_W)) // [RULE_10]
      else $error("reload value not loaded");
   a_wdt_key_rst: assert property (!st_reg.rst_n |=> wdt_en) // [RULE_09]
      else $error("watchdog disabled after reset");
   a_wdt_pulse_len: assert property ($rose(st_reg.wdt_pulse)
      |-> st_reg.wdt_pulse [*8]) // [RULE_14]
      else $error("watchdog pulse too short");
   a_rst_pin: assert property (!st_reg.pin_s |=> !o_int_rst_n) // [RULE_16]
      else $error("pin reset not merged");

   // Strobe spacing in clocks
   localparam int MC_GAP  = MC_DIV;
   localparam int SMP_GAP = SE0_SMP_CYC;

   a_mc_period: assert property (mc_tick |-> ##MC_GAP mc_tick) // [RULE_13]
      else $error("machine cycle period wrong");
   a_mc_gap: assert property (mc_tick |=> !mc_tick [*8]) // [RULE_13]
      else $error("machine cycle tick too soon");
   a_smp_period: assert property (smp_tick |-> ##SMP_GAP smp_tick) // [RULE_05]
      else $error("sample period wrong");
   a_lvr_hold_rst: assert property (st_reg.lvr_hold |=> !o_int_rst_n) // [RULE_01]
      else $error("hold did not keep reset");
   a_lvr_hold_cnt: assert property (st_reg.lvr_hold
      |-> st_reg.lvr_cnt < LVR_CW'(P_LVR_HOLD_CYC)) // [RULE_01]
      else $error("hold counter overran");
   a_pulse_rst: assert property (st_reg.wdt_pulse |=> !o_int_rst_n) // [RULE_16]
      else $error("watchdog pulse did not reset");
   a_pulse_cnt: assert property (st_reg.wdt_pulse
      |-> st_reg.pulse_cnt < PULSE_CW'(P_WDT_PULSE_MC)) // [RULE_14]
      else $error("pulse counter overran");
   a_wdt_clr_rst: assert property (!st_reg.rst_n
      |=> st_reg.watchdog_counter == '0) // [RULE_09]
      else $error("watchdog counter kept in reset");
   a_wdt_key_wr: assert property (wr_key && st_reg.rst_n
      |=> st_reg.wdt_key == $past(i_sfr_wdata)) // [RULE_12]
      else $error("key write not taken");
   a_uie_bit: assert property (wr_uie |=> st_reg.bus_reset_cpu_enable
      == $past(i_sfr_wdata[UIE_RST_CPU_BIT])) // [RULE_06]
      else $error("bus reset enable not taken");
   a_flag_clear: assert property (wr_uis && i_sfr_wdata[UIS_RST_FLAG_BIT]
      && !(smp_tick && st_reg.se0_s
      && st_reg.se0_run == RUN_W'(SE0_MIN - 1))
      |=> !st_reg.bus_reset_flag) // [RULE_05]
      else $error("bus reset flag not cleared");
   a_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata)) // [RULE_12]
      else $error("read data moved without read");
endmodule

// file: sim/wdrs_cpu_model.sv
`timescale 1ns/1ps
module wdrs_cpu_model (
   // Clock
   input  wire logic                        i_clk,
   // SFR bus toward the block
   input  wire logic [wdrs_pkg::SFR_W-1:0]  i_sfr_rdata,
   output logic      [wdrs_pkg::SFR_W-1:0]  o_sfr_addr,
   output logic      [wdrs_pkg::SFR_W-1:0]  o_sfr_wdata,
   output logic                             o_sfr_wr,
   output logic                             o_sfr_rd
);
   import wdrs_pkg::*;

   initial begin
      o_sfr_addr  = 8'h00;
      o_sfr_wdata = 8'h00;
      o_sfr_wr    = 1'b0;
      o_sfr_rd    = 1'b0;
   end

   // Idle bus shows inverted values, not the last ones
   task sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_sfr_addr  = a;
      o_sfr_wdata = d;
      o_sfr_wr    = 1'b1;
      @(posedge i_clk);
      #1;
      o_sfr_wr    = 1'b0;
      o_sfr_addr  = ~a;
      o_sfr_wdata = ~d;
   endtask

   // Read data holds, so it is taken one edge later
   task sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_sfr_addr = a;
      o_sfr_rd   = 1'b1;
      @(posedge i_clk);
      #1;
      o_sfr_rd   = 1'b0;
      o_sfr_addr = ~a;
      @(posedge i_clk);
      #1;
      d = i_sfr_rdata;
   endtask

   // Periodic service, reload value kept within 00..7F
   task service(input logic [6:0] v);
      sfr_write(ADDR_WDT_RELOAD, {1'b0, v});
   endtask
endmodule

// file: sim/wdrs_top_tb.sv
`timescale 1ns/1ps
module wdrs_top_tb;
   import wdrs_pkg::*;
   localparam int unsigned HOLD  = 16;
   localparam int unsigned PULSE = 16;
   logic             i_clk;
   logic             i_rst_n;
   logic             rst_pin_n;
   logic             low_volt;
   logic             usb_se0;
   logic [SFR_W-1:0] sfr_addr;
   logic [SFR_W-1:0] sfr_wdata;
   logic             sfr_wr;
   logic             sfr_rd;
   logic [SFR_W-1:0] sfr_rdata;
   logic             int_rst_n;
   logic [7:0]       rd_val;
   int               n_errors;
   int               num_checks;
   int               n;

   initial i_clk = 1'b0;
   always #25 i_clk = ~i_clk;

   wdrs_top #(.P_LVR_HOLD_CYC(HOLD), .P_WDT_PULSE_MC(PULSE)) i_wdrs_top (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rst_pin_n(rst_pin_n),
      .i_low_volt(low_volt), .i_usb_se0(usb_se0),
      .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata),
      .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
      .o_sfr_rdata(sfr_rdata), .o_int_rst_n(int_rst_n));

   wdrs_cpu_model i_wdrs_cpu_model (
      .i_clk(i_clk), .i_sfr_rdata(sfr_rdata), .o_sfr_addr(sfr_addr),
      .o_sfr_wdata(sfr_wdata), .o_sfr_wr(sfr_wr), .o_sfr_rd(sfr_rd));

   task check(input logic [7:0] got, input logic [7:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_wdrs_cpu_model.sfr_read(a, rd_val);
      check(rd_val, exp, "read data");
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      i_wdrs_cpu_model.sfr_write(a, d);
   endtask

   task cyc(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask

   task wait_up(input int max, output int cnt);
      cnt = 0;
      while (int_rst_n !== 1'b1 && cnt < max) begin
         cyc(1);
         cnt++;
      end
   endtask

   task rst_is(input logic exp, input string m);
      check({7'h00, int_rst_n}, {7'h00, exp}, m);
   endtask

   task t_regs;
      rd_chk(ADDR_WDT_KEY, 8'h00);
      rd_chk(ADDR_PWR_CTRL, 8'h00);
      rd_chk(ADDR_USB_IRQ_EN, 8'h00);
      rd_chk(ADDR_USB_IRQ_STA, 8'h00);
      i_wdrs_cpu_model.service(7'h1E);
      rd_chk(ADDR_WDT_RELOAD, 8'h00);
      rd_chk(8'h3C, 8'h00);
      wr(ADDR_WDT_KEY, WDT_KEY_DIS);
      rd_chk(ADDR_WDT_KEY, 8'h55);
      wr(ADDR_WDT_KEY, 8'hAA);
      rd_chk(ADDR_WDT_KEY, 8'hAA);
      $display("test regs done");
   endtask

   task t_pin;
      wr(ADDR_WDT_KEY, WDT_KEY_DIS);
      rst_pin_n = 1'b0;
      cyc(4);
      rst_is(1'b0, "pin reset");
      rst_pin_n = 1'b1;
      wait_up(10, n);
      rst_is(1'b1, "pin release");
      rd_chk(ADDR_WDT_KEY, 8'h00);
      $display("test pin done");
   endtask

   task t_lvr;
      low_volt = 1'b1;
      cyc(5);
      rst_is(1'b0, "low volt reset");
      low_volt = 1'b0;
      wait_up(HOLD + 10, n);
      check({7'h00, n >= HOLD}, 8'h01, "stretch short");
      rst_is(1'b1, "stretch end");
      wr(ADDR_PWR_CTRL, 8'h20);
      rd_chk(ADDR_PWR_CTRL, 8'h20);
      low_volt = 1'b1;
      cyc(6);
      rst_is(1'b1, "low volt disabled");
      low_volt = 1'b0;
      wr(ADDR_PWR_CTRL, 8'h00);
      $display("test lvr done");
   endtask

   task t_usb;
      usb_se0 = 1'b1;
      cyc(30);
      usb_se0 = 1'b0;
      cyc(4);
      rd_chk(ADDR_USB_IRQ_STA, 8'h00);
      usb_se0 = 1'b1;
      cyc(110);
      rst_is(1'b1, "bus reset not enabled");
      usb_se0 = 1'b0;
      cyc(4);
      rd_chk(ADDR_USB_IRQ_STA, 8'h01);
      wr(ADDR_USB_IRQ_STA, 8'h01);
      rd_chk(ADDR_USB_IRQ_STA, 8'h00);
      wr(ADDR_USB_IRQ_EN, 8'h40);
      rd_chk(ADDR_USB_IRQ_EN, 8'h40);
      usb_se0 = 1'b1;
      cyc(110);
      rst_is(1'b0, "bus reset to cpu");
      usb_se0 = 1'b0;
      wait_up(20, n);
      rst_is(1'b1, "bus reset release");
      rd_chk(ADDR_USB_IRQ_EN, 8'h40);
      $display("test usb done");
   endtask

   task end_of_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #(50 * 5000);
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      end_of_test();
   end

   initial begin
      n_errors   = 0;
      num_checks = 0;
      i_rst_n    = 1'b0;
      rst_pin_n  = 1'b1;
      low_volt   = 1'b0;
      usb_se0    = 1'b0;
      cyc(3);
      i_rst_n = 1'b1;
      wait_up(20, n);
      rst_is(1'b1, "leave reset");
      t_regs();
      t_pin();
      t_lvr();
      t_usb();
      end_of_test();
   end
endmodule
